/* File: src/mcts_top.sv */
// per-channel setup, counters and pin levels of the five-channel timer
// ------------------------------------------------------------------
// Notes on behaviour
// R1 - five channels, each with 16-bit counter
// R2 - prescaler field picks one of eight clocks
// R3 - 8-bit rw counter control per channel
// R4 - clear codes 000 none, A, B, sync
// R5 - channels 0,3,4 add none, C, D, sync
// R6 - buffered C or D never clears counter
// R7 - sync clear only with synchro bit set
// R8 - channels 1,2 bit 7 reads zero
// R9 - channels 1,2 ignore prescaler in phase counting
// R10 - 8-bit rw mode register per channel
// R11 - no second PWM mode on channels 3,4
// R12 - phase counting only on channels 1,2
// R13 - channel 4 follows channel 3 pair modes
// R14 - software never sets pair modes elsewhere
// R15 - buffer operation only on channels 0,3,4
// R16 - eight pin control registers in total
// R17 - initial level drives pin while halted
// R18 - second PWM mode: level at counter clear
// R19 - buffered C or D ignores pin control
// R20 - pins low after reset until written
// R21 - buffer bit turns C/D into buffer
// ------------------------------------------------------------------
//
// Local design decisions: the address-and-strobe port and the address map.
`timescale 1ns/1ps
module mcts_top
  import mcts_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst,
  input wire mcts_bus_t bus,
  output logic [7:0] rd_data,
  input wire logic [NCH-1:0] start_bits,
  input wire logic [NCH-1:0] sync_bits,
  input wire logic [NCH-1:0] cnt_tick,
  input wire logic [NCH-1:0][3:0] hit_evt,
  input wire logic [NPIN-1:0] run_level,
  output mcts_cfg_t [NCH-1:0] cfg_out,
  output logic [NCH-1:0][CNT_W-1:0] cnt_val,
  output logic [NPIN-1:0] pin_level,
  output logic [NPIN-1:0] pin_oe
);

  // ----------------------------------------------------------------
  // storage
  // ----------------------------------------------------------------
  logic [7:0] ctrl_reg [NCH];
  logic [7:0] mode_reg [NCH];
  logic [7:0] pin_reg [NPINREG];
  logic [NPINREG-1:0] pin_wr_reg;
  logic [7:0] rd_data_reg;
  mcts_cfg_t [NCH-1:0] cfg_reg;
  mcts_cfg_t [NCH-1:0] cfg_next;
  logic [NCH-1:0][CNT_W-1:0] cnt_reg;
  logic [NPIN-1:0] pin_level_reg;
  logic [NPIN-1:0] pin_oe_reg;
  logic [NCH-1:0] own_clr;
  logic [NCH-1:0] clr_now;
  logic [3:0] md_eff [NCH];

  // ----------------------------------------------------------------
  // register writes
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < NCH; i++) begin
        ctrl_reg[i] <= CTRL_RST;
      end
    end else if (bus.wr) begin
      for (int i = 0; i < NCH; i++) begin
        if (bus.addr == OFS_CTRL + ADDR_W'(i)) begin
          ctrl_reg[i] <= bus.wdata; // R3
          if (!has_cd(i)) begin
            ctrl_reg[i][CLR_MSB] <= 1'b0; // R8
          end
        end
      end
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < NCH; i++) begin
        mode_reg[i] <= MODE_RST;
      end
    end else if (bus.wr) begin
      for (int i = 0; i < NCH; i++) begin
        if (bus.addr == OFS_MODE + ADDR_W'(i)) begin
          // illegal mode codes keep the old mode
          if (mode_legal(i, bus.wdata[MD_MSB:MD_LSB])) begin
            mode_reg[i][MD_MSB:MD_LSB] <= bus.wdata[MD_MSB:MD_LSB]; // R10 R11 R12 R14
          end
          if (has_cd(i)) begin
            mode_reg[i][BUF_D_BIT] <= bus.wdata[BUF_D_BIT]; // R15 R21
            mode_reg[i][BUF_C_BIT] <= bus.wdata[BUF_C_BIT]; // R15 R21
          end
        end
      end
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < NPINREG; i++) begin
        pin_reg[i] <= PIN_RST;
      end
      pin_wr_reg <= '0;
    end else if (bus.wr) begin
      for (int i = 0; i < NPINREG; i++) begin
        if (bus.addr == OFS_PIN + ADDR_W'(i)) begin
          pin_reg[i] <= bus.wdata; // R16
          pin_wr_reg[i] <= 1'b1; // R20
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // register reads, data in the following cycle only
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      rd_data_reg <= 8'h00;
    end else begin
      rd_data_reg <= 8'h00;
      if (bus.rd) begin
        for (int i = 0; i < NCH; i++) begin
          if (bus.addr == OFS_CTRL + ADDR_W'(i)) begin
            rd_data_reg <= ctrl_reg[i]; // R3
          end
          if (bus.addr == OFS_MODE + ADDR_W'(i)) begin
            rd_data_reg <= mode_reg[i]; // R10
          end
        end
        for (int i = 0; i < NPINREG; i++) begin
          if (bus.addr == OFS_PIN + ADDR_W'(i)) begin
            rd_data_reg <= pin_reg[i];
          end
        end
      end
    end
  end

  assign rd_data = rd_data_reg;

  // ----------------------------------------------------------------
  // effective channel setup
  // ----------------------------------------------------------------
  always_comb begin
    for (int i = 0; i < NCH; i++) begin
      md_eff[i] = mode_reg[i][MD_MSB:MD_LSB];
    end
    if (is_pair(mode_reg[3][MD_MSB:MD_LSB])) begin
      md_eff[4] = mode_reg[3][MD_MSB:MD_LSB]; // R13
    end
  end

  always_comb begin
    for (int i = 0; i < NCH; i++) begin
      cfg_next[i].presc = ctrl_reg[i][PSC_MSB:PSC_LSB]; // R2
      cfg_next[i].presc_used = has_cd(i) || !is_phase(md_eff[i]); // R9
      cfg_next[i].clk_edge = ctrl_reg[i][EDGE_MSB:EDGE_LSB];
      cfg_next[i].mode = md_eff[i];
      cfg_next[i].buf_c = mode_reg[i][BUF_C_BIT]; // R21
      cfg_next[i].buf_d = mode_reg[i][BUF_D_BIT]; // R21
      unique case (ctrl_reg[i][CLR_MSB:CLR_LSB])
        CLR_OFF0, CLR_OFF1: cfg_next[i].clear_src = MCTS_CLR_OFF; // R4 R5
        CLR_GA: cfg_next[i].clear_src = MCTS_CLR_A; // R4
        CLR_GB: cfg_next[i].clear_src = MCTS_CLR_B; // R4
        CLR_GC: cfg_next[i].clear_src = mode_reg[i][BUF_C_BIT] ? MCTS_CLR_OFF : MCTS_CLR_C; // R5 R6
        CLR_GD: cfg_next[i].clear_src = mode_reg[i][BUF_D_BIT] ? MCTS_CLR_OFF : MCTS_CLR_D; // R5 R6
        CLR_SYN0, CLR_SYN1: cfg_next[i].clear_src = sync_bits[i] ? MCTS_CLR_SYNC : MCTS_CLR_OFF; // R7
      endcase
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      cfg_reg <= '0;
    end else begin
      cfg_reg <= cfg_next;
    end
  end

  assign cfg_out = cfg_reg;

  // ----------------------------------------------------------------
  // counters and their clearing
  // ----------------------------------------------------------------
  always_comb begin
    for (int i = 0; i < NCH; i++) begin
      unique case (cfg_reg[i].clear_src)
        MCTS_CLR_A: own_clr[i] = start_bits[i] && hit_evt[i][0];
        MCTS_CLR_B: own_clr[i] = start_bits[i] && hit_evt[i][1];
        MCTS_CLR_C: own_clr[i] = start_bits[i] && hit_evt[i][2] && !cfg_reg[i].buf_c; // R21
        MCTS_CLR_D: own_clr[i] = start_bits[i] && hit_evt[i][3] && !cfg_reg[i].buf_d; // R21
        default: own_clr[i] = 1'b0;
      endcase
    end
  end

  always_comb begin
    for (int i = 0; i < NCH; i++) begin
      clr_now[i] = own_clr[i];
      if (cfg_reg[i].clear_src == MCTS_CLR_SYNC && start_bits[i]) begin
        clr_now[i] = |(own_clr & sync_bits & ~(NCH'(1) << i)); // R7
      end
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      cnt_reg <= '0;
    end else begin
      for (int i = 0; i < NCH; i++) begin
        if (clr_now[i]) begin
          cnt_reg[i] <= CNT_RST; // R4
        end else if (start_bits[i] && cnt_tick[i]) begin
          cnt_reg[i] <= cnt_reg[i] + CNT_W'(1); // R1
        end
      end
    end
  end

  assign cnt_val = cnt_reg;

  // ----------------------------------------------------------------
  // pin levels and enables
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      pin_level_reg <= '0;
      pin_oe_reg <= '1;
    end else begin
      for (int p = 0; p < NPIN; p++) begin
        automatic int ch = pin_chan(p);
        automatic logic [3:0] nib = p[0] ? pin_reg[p / 2][7:4] : pin_reg[p / 2][3:0];
        automatic logic is_buf = has_cd(ch) && p[1] &&
                                 (p[0] ? mode_reg[ch][BUF_D_BIT] : mode_reg[ch][BUF_C_BIT]);
        if (!pin_wr_reg[p / 2]) begin
          pin_level_reg[p] <= 1'b0; // R20
          pin_oe_reg[p] <= 1'b1; // R20
        end else if (is_buf) begin
          pin_level_reg[p] <= 1'b0; // R19
          pin_oe_reg[p] <= 1'b0; // R19
        end else begin
          pin_oe_reg[p] <= !nib[PIN_CAP_BIT] && (nib[1:0] != 2'h0);
          if (!start_bits[ch]) begin
            pin_level_reg[p] <= nib[PIN_LVL_BIT]; // R17
          end else if (md_eff[ch] == MD_PWM2 && clr_now[ch]) begin
            pin_level_reg[p] <= nib[PIN_LVL_BIT]; // R18
          end else begin
            pin_level_reg[p] <= run_level[p];
          end
        end
      end
    end
  end

  assign pin_level = pin_level_reg;
  assign pin_oe = pin_oe_reg;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  AST_CH12_BIT7: assert property (!ctrl_reg[1][CLR_MSB] && !ctrl_reg[2][CLR_MSB]) // R8
    else $error("reserved bit 7 set on channel 1 or 2");
  AST_READ_NEXT: assert property (bus.rd && bus.addr == OFS_MODE |=> rd_data == $past(mode_reg[0])) // R10
    else $error("mode read data wrong in following cycle");
  AST_NO_PWM2: assert property (mode_reg[3][MD_MSB:MD_LSB] != MD_PWM2 && mode_reg[4][MD_MSB:MD_LSB] != MD_PWM2) // R11
    else $error("second PWM mode on channel 3 or 4");
  AST_NO_PHASE: assert property (!is_phase(mode_reg[0][3:0]) && !is_phase(mode_reg[3][3:0])) // R12
    else $error("phase counting on a channel without it");
  AST_FOLLOW: assert property (is_pair(mode_reg[3][3:0]) ##1 is_pair(mode_reg[3][3:0]) |-> // R13
    cfg_out[4].mode == $past(mode_reg[3][3:0]))
    else $error("channel 4 does not follow channel 3");
  AST_BUF_CH12: assert property (mode_reg[1][5:4] == 2'h0 && mode_reg[2][5:4] == 2'h0) // R15
    else $error("buffer bit set on channel 1 or 2");
  AST_NO_BUF_CLR: assert property (mode_reg[0][BUF_C_BIT] && ctrl_reg[0][7:5] == CLR_GC |=> // R6
    cfg_out[0].clear_src == MCTS_CLR_OFF)
    else $error("buffered register still selected as clear source");
  AST_SYNC_GATE: assert property (!sync_bits[0] |=> cfg_out[0].clear_src != MCTS_CLR_SYNC) // R7
    else $error("sync clear without synchro bit");
  AST_HALT_LVL: assert property (pin_wr_reg[0] && !start_bits[0] && !mode_reg[0][BUF_C_BIT] |=> // R17
    pin_level[0] == $past(pin_reg[0][PIN_LVL_BIT]))
    else $error("halted pin not at initial level");
  AST_POR_LOW: assert property (!pin_wr_reg[2] |=> !pin_level[4] && !pin_level[5]) // R20
    else $error("pin not low before first pin control write");
  AST_PRESC_PHASE: assert property (is_phase(mode_reg[1][3:0]) |=> !cfg_out[1].presc_used) // R9
    else $error("prescaler used in phase counting");

  COV_PAIR: cover property (is_pair(mode_reg[3][3:0]) ##1 cfg_out[4].mode == mode_reg[3][3:0]);
  COV_SYNC_CLR: cover property (cfg_reg[1].clear_src == MCTS_CLR_SYNC && clr_now[1]);
  COV_BUF: cover property (mode_reg[3][BUF_D_BIT] && hit_evt[3][3] && start_bits[3]);
  COV_PIN_WR: cover property (!pin_wr_reg[0] ##1 pin_wr_reg[0]);

endmodule // mcts_top

/* File: inc/mcts_pkg.sv */
// constants, types and helpers of the multi-channel timer setup block
package mcts_pkg;

  // ----------------------------------------------------------------
  // sizes
  // ----------------------------------------------------------------
  localparam int NCH = 5;
  localparam int CNT_W = 16;
  localparam int NPIN = 16;
  localparam int NPINREG = 8;
  localparam int ADDR_W = 5;

  // ----------------------------------------------------------------
  // register indices (channel n, or pin register n, at base plus n)
  // ----------------------------------------------------------------
  localparam logic [ADDR_W-1:0] OFS_CTRL = 5'h00;
  localparam logic [ADDR_W-1:0] OFS_MODE = 5'h05;
  localparam logic [ADDR_W-1:0] OFS_PIN = 5'h0A;

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [7:0] MODE_RST = 8'h00;
  localparam logic [7:0] PIN_RST = 8'h00;
  localparam logic [CNT_W-1:0] CNT_RST = 16'h0000;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int CLR_MSB = 7;
  localparam int CLR_LSB = 5;
  localparam int EDGE_MSB = 4;
  localparam int EDGE_LSB = 3;
  localparam int PSC_MSB = 2;
  localparam int PSC_LSB = 0;
  localparam int BUF_D_BIT = 5;
  localparam int BUF_C_BIT = 4;
  localparam int MD_MSB = 3;
  localparam int MD_LSB = 0;
  localparam int PIN_CAP_BIT = 3;
  localparam int PIN_LVL_BIT = 2;

  // ----------------------------------------------------------------
  // clear source and mode codes
  // ----------------------------------------------------------------
  localparam logic [2:0] CLR_OFF0 = 3'h0;
  localparam logic [2:0] CLR_GA = 3'h1;
  localparam logic [2:0] CLR_GB = 3'h2;
  localparam logic [2:0] CLR_SYN0 = 3'h3;
  localparam logic [2:0] CLR_OFF1 = 3'h4;
  localparam logic [2:0] CLR_GC = 3'h5;
  localparam logic [2:0] CLR_GD = 3'h6;
  localparam logic [2:0] CLR_SYN1 = 3'h7;
  localparam logic [3:0] MD_NORMAL = 4'h0;
  localparam logic [3:0] MD_PWM2 = 4'h3;
  localparam logic [1:0] MD_PHASE_TOP = 2'h1;
  localparam logic [3:0] MD_RSYNC = 4'h8;
  localparam logic [1:0] MD_CMP_TOP = 2'h3;

  typedef enum logic [2:0] {
    MCTS_CLR_OFF, MCTS_CLR_A, MCTS_CLR_B, MCTS_CLR_C, MCTS_CLR_D, MCTS_CLR_SYNC
  } mcts_clr_t;

  typedef struct packed {
    mcts_clr_t clear_src;
    logic [2:0] presc;
    logic presc_used;
    logic [1:0] clk_edge;
    logic [3:0] mode;
    logic buf_c;
    logic buf_d;
  } mcts_cfg_t;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } mcts_bus_t;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic is_phase(input logic [3:0] md);
    return md[3:2] == MD_PHASE_TOP;
  endfunction

  function automatic logic is_pair(input logic [3:0] md);
    return (md == MD_RSYNC) || ((md[3:2] == MD_CMP_TOP) && (md[1:0] != 2'h0));
  endfunction

  function automatic logic has_cd(input int ch);
    return (ch == 0) || (ch == 3) || (ch == 4);
  endfunction

  function automatic logic mode_legal(input int ch, input logic [3:0] md);
    if (md == MD_PWM2 && (ch == 3 || ch == 4))
      return 1'b0;
    if (is_phase(md) && has_cd(ch))
      return 1'b0;
    if (is_pair(md) && ch != 3)
      return 1'b0;
    return 1'b1;
  endfunction

  function automatic int pin_chan(input int p);
    if (p < 4)
      return 0;
    if (p < 6)
      return 1;
    if (p < 8)
      return 2;
    if (p < 12)
      return 3;
    return 4;
  endfunction

endpackage

/* File: tb/mcts_top_test.sv */
// self-checking testbench of the multi-channel timer setup block
`timescale 1ns/1ps
module mcts_top_test
  import mcts_pkg::*;
();
  // ----------------------------------------------------------------
  // signals
  // ----------------------------------------------------------------
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  mcts_bus_t bus = '0;
  logic [7:0] rd_data;
  logic [NCH-1:0] start_bits = '0;
  logic [NCH-1:0] sync_bits = '0;
  logic [NCH-1:0] cnt_tick = '0;
  logic [NCH-1:0][3:0] hit_evt = '0;
  logic [NPIN-1:0] run_level = '0;
  mcts_cfg_t [NCH-1:0] cfg_out;
  logic [NCH-1:0][CNT_W-1:0] cnt_val;
  logic [NPIN-1:0] pin_level;
  logic [NPIN-1:0] pin_oe;
  int bad_count = 0;
  int tests_run = 0;
  int cycles = 0;
  logic [7:0] rv;
  logic a0;
  logic a1;
  mcts_clr_t exp_clr [8];
  bit cd;
  bit ok;

  mcts_top DUT (.core_clk(core_clk), .rst(rst), .bus(bus), .rd_data(rd_data), .start_bits(start_bits),
    .sync_bits(sync_bits), .cnt_tick(cnt_tick), .hit_evt(hit_evt), .run_level(run_level),
    .cfg_out(cfg_out), .cnt_val(cnt_val), .pin_level(pin_level), .pin_oe(pin_oe));

  always #25 core_clk = ~core_clk;

  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task automatic end_sim();
    $display("checks %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [ADDR_W-1:0] a, input logic [7:0] d);
    @(posedge core_clk);
    bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge core_clk);
    bus.wr <= 1'b0;
  endtask

  task automatic rd(input logic [ADDR_W-1:0] a, output logic [7:0] d);
    @(posedge core_clk);
    bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge core_clk);
    bus.rd <= 1'b0;
    @(negedge core_clk);
    d = rd_data;
  endtask

  task automatic settle();
    repeat (2) @(posedge core_clk);
    @(negedge core_clk);
  endtask

  // ----------------------------------------------------------------
  // timeout
  // ----------------------------------------------------------------
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 6000) begin
      bad_count++;
      end_sim();
    end
  end

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    exp_clr = '{MCTS_CLR_OFF, MCTS_CLR_A, MCTS_CLR_B, MCTS_CLR_SYNC,
                MCTS_CLR_OFF, MCTS_CLR_C, MCTS_CLR_D, MCTS_CLR_SYNC};
    repeat (6) @(posedge core_clk);
    rst <= 1'b0;
    @(negedge core_clk);
    chk(pin_level, 16'h0000);
    chk(pin_oe, 16'hFFFF);
    for (int i = 0; i < NCH; i++) begin
      chk(cnt_val[i], 16'h0000);
    end
    for (int i = 0; i < 19; i++) begin
      rd(i[ADDR_W-1:0], rv);
      chk(rv, 8'h00);
    end
    // control registers, reserved bit and prescaler
    for (int c = 0; c < NCH; c++) begin
      wr(OFS_CTRL + c[ADDR_W-1:0], 8'hFF);
      rd(OFS_CTRL + c[ADDR_W-1:0], rv);
      chk(rv, (c == 1 || c == 2) ? 8'h7F : 8'hFF);
    end
    settle();
    chk(cfg_out[0].presc, 3'h7);
    chk(cfg_out[0].clk_edge, 2'h3);
    wr(OFS_MODE + 5'h01, 8'h04);
    settle();
    chk(cfg_out[1].presc_used, 1'b0);
    wr(OFS_MODE + 5'h01, 8'h00);
    settle();
    chk(cfg_out[1].presc_used, 1'b1);
    // clear source decoding
    for (int k = 0; k < 8; k++) begin
      sync_bits <= 5'h1F;
      wr(OFS_CTRL, 8'(k << 5));
      wr(OFS_CTRL + 5'h01, 8'(k << 5));
      settle();
      chk(cfg_out[0].clear_src, exp_clr[k]);
      chk(cfg_out[1].clear_src, exp_clr[k & 3]);
    end
    sync_bits <= 5'h1E;
    wr(OFS_CTRL, 8'h60);
    settle();
    chk(cfg_out[0].clear_src, MCTS_CLR_OFF);
    // mode legality and buffer bits on every channel
    for (int c = 0; c < NCH; c++) begin
      cd = (c == 0 || c >= 3);
      for (int m = 0; m < 16; m++) begin
        ok = !((m == 3 && c >= 3) || (m >= 4 && m <= 7 && cd) || ((m == 8 || m >= 13) && c != 3));
        wr(OFS_MODE + c[ADDR_W-1:0], 8'h00);
        wr(OFS_MODE + c[ADDR_W-1:0], 8'hF0 | 8'(m));
        rd(OFS_MODE + c[ADDR_W-1:0], rv);
        chk(rv, {2'b00, cd, cd, ok ? 4'(m) : 4'h0});
      end
      wr(OFS_MODE + c[ADDR_W-1:0], 8'h00);
    end
    // channel 4 follows channel 3 in paired modes
    wr(OFS_MODE + 5'h03, 8'h08);
    wr(OFS_MODE + 5'h04, 8'h02);
    settle();
    chk(cfg_out[4].mode, 4'h8);
    wr(OFS_MODE + 5'h03, 8'h00);
    settle();
    chk(cfg_out[4].mode, 4'h2);
    // buffered C and D never clear
    wr(OFS_MODE, 8'h10);
    wr(OFS_CTRL, 8'hA0);
    settle();
    chk(cfg_out[0].clear_src, MCTS_CLR_OFF);
    chk(cfg_out[0].buf_c, 1'b1);
    wr(OFS_MODE, 8'h20);
    wr(OFS_CTRL, 8'hC0);
    settle();
    chk(cfg_out[0].clear_src, MCTS_CLR_OFF);
    wr(OFS_MODE, 8'h00);
    settle();
    chk(cfg_out[0].clear_src, MCTS_CLR_D);
    // counting and clear on A
    wr(OFS_CTRL + 5'h02, 8'h20);
    @(posedge core_clk);
    start_bits <= 5'h04;
    cnt_tick <= 5'h04;
    repeat (3) @(posedge core_clk);
    cnt_tick <= 5'h00;
    @(negedge core_clk);
    chk(cnt_val[2], 16'h0003);
    @(posedge core_clk);
    hit_evt[2][0] <= 1'b1;
    @(posedge core_clk);
    hit_evt[2][0] <= 1'b0;
    @(negedge core_clk);
    chk(cnt_val[2], 16'h0000);
    start_bits <= 5'h00;
    // pin levels
    wr(OFS_PIN, 8'h15);
    settle();
    chk(pin_level[2:0], 3'b001);
    chk(pin_oe[2:0], 3'b111);
    wr(OFS_PIN + 5'h01, 8'h5D);
    settle();
    chk(pin_oe[3:2], 2'b10);
    chk(pin_level[3], 1'b1);
    wr(OFS_PIN + 5'h01, 8'h55);
    wr(OFS_MODE, 8'h10);
    settle();
    chk({pin_level[2], pin_oe[2]}, 2'b00);
    wr(OFS_MODE, 8'h03);
    wr(OFS_CTRL, 8'h20);
    @(posedge core_clk);
    start_bits <= 5'h01;
    settle();
    chk(pin_level[0], 1'b0);
    @(posedge core_clk);
    hit_evt[0][0] <= 1'b1;
    @(posedge core_clk);
    hit_evt[0][0] <= 1'b0;
    @(negedge core_clk);
    a0 = pin_level[0];
    @(negedge core_clk);
    a1 = pin_level[0];
    chk(a0 | a1, 1'b1);
    start_bits <= 5'h00;
    settle();
    chk(pin_level[0], 1'b1);
    end_sim();
  end
endmodule // mcts_top_test
